/* dsr_pkg.sv */
// Notes on behaviour
// R1: Self-refresh entry accepted in 1x, 2x or 4x mode, any refresh count.
// R2: 2x modes: controller keeps REF2x count even, else adds extra refresh.
// R3: 4x modes: controller keeps REF4x count multiple of four, else extra.
// R4: Extra post-exit refreshes excluded from average interval accounting.
// R5: Entry decoded when CS_n, RAS_n, CAS_n, CKE low and WE_n, ACT_n high.
// R6: Controller enters only when idle, precharged and all timings met.
// R7: CKE held low keeps self refresh; other inputs ignored meanwhile.
// R8: Termination off in self refresh, back on after exit.
// R9: DLL off on entry, on again with DLL reset on exit.
// R10: Internal timer refreshes, first within tCKE; internal clock gated.
// R11: Reference-generator bit: writes after tXS if kept on, else tXSDLL.
// R12: Controller stays in self refresh at least tCKESR or tCKESR_PAR.
// R13: Clock may stop after tCKSRE, must be stable tCKSRX before exit.
// R14: Exit is CKE high with deselect; tXS before non-DLL commands.
// R15: ZQ and restricted mode writes allowed after tXS_FAST.
// R16: Reads and writes wait tXSDLL after exit.
// R17: Deselect during tXS; CKE stays high through tXSDLL.
// R18: ODT input held off through tXSDLL after exit.
// R19: One extra refresh and tXS before re-entering self or power-down.
// R20: CAL latency added to every tXS, tXS_FAST and tXSDLL delay.
// R21: tXS equals 1x refresh cycle time plus 10 ns.
// R22: Abort bit: stop ongoing refresh, no counter step, tXS_ABORT applies.
// R23: 2x and 4x modes refresh at two and four times base rate.
// R24: Timings are cycle counts; exit counters start at the exit edge.
package dsr_pkg;
   localparam int CLK_MHZ        = 125;
   localparam int TRFC1_NS       = 350;
   localparam int TRFC4_NS       = 160;
   localparam int TXS_EXTRA_NS   = 10;
   // Least times round up
   localparam int TXS_CYC        = ((TRFC1_NS + TXS_EXTRA_NS) * CLK_MHZ + 999) / 1000;
   localparam int TXS_FAST_CYC   = ((TRFC4_NS + TXS_EXTRA_NS) * CLK_MHZ + 999) / 1000;
   localparam int TXS_ABORT_CYC  = TXS_FAST_CYC;
   localparam int TXSDLL_CYC     = 768;
   localparam int TCKE_NS        = 5;
   localparam int TCKE_CYC       = (TCKE_NS * CLK_MHZ + 999) / 1000;
   localparam int TREFI_NS       = 7800;
   localparam int TREFI_CYC      = TREFI_NS * CLK_MHZ / 1000;
   localparam int TRFC_INT_CYC   = (TRFC1_NS * CLK_MHZ + 999) / 1000;
   localparam int TCAL_CYC       = 3;
   localparam int CNT_W          = 16;

   localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
   localparam logic [31:0] ADDR_REFCNT = 32'h0000_0008;
   localparam logic [31:0] ADDR_TXS    = 32'h0000_000c;
   localparam logic [31:0] ADDR_TXSF   = 32'h0000_0010;
   localparam logic [31:0] ADDR_TXSDLL = 32'h0000_0014;
   localparam logic [31:0] ADDR_TXSAB  = 32'h0000_0018;
   localparam logic [31:0] ADDR_TCAL   = 32'h0000_001c;

   localparam int CTRL_VREF_ON_BIT = 0;
   localparam int CTRL_ABORT_BIT   = 1;
   localparam int CTRL_CAL_EN_BIT  = 2;
   localparam int CTRL_DLL_EN_BIT  = 3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0008;

   typedef struct packed {
      logic cs_n;
      logic act_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
   } dsr_cmd_s;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } dsr_apb_req_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } dsr_apb_rsp_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SR   = 4'b0010,
      ST_EXIT = 4'b0100,
      ST_POST = 4'b1000
   } dsr_state_e;
endpackage

/* dsr_refresh_timer.sv */
`timescale 1ns/1ps
// Internal refresh engine used while in self refresh
module dsr_refresh_timer
   import dsr_pkg::*;
#(
   parameter int INTERVAL = TREFI_CYC,
   parameter int FIRST    = TCKE_CYC,
   parameter int BUSY     = TRFC_INT_CYC
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   // Control
   input  wire logic             run_i,
   input  wire logic             abort_i,
   // Status
   output logic                  busy_o,
   output logic [CNT_W-1:0]      count_o
);
   initial begin
      if (INTERVAL <= FIRST + BUSY || FIRST < 1 || INTERVAL >= 2**CNT_W)
         $error("dsr_refresh_timer: bad timing parameters");
   end

   typedef struct packed {
      logic [CNT_W-1:0] tick;
      logic [CNT_W-1:0] busy_cnt;
      logic             busy;
      logic [CNT_W-1:0] count;
   } dsr_tmr_s;

   dsr_tmr_s st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!run_i) begin
         // Abort leaves the counter unstepped; otherwise finish the refresh
         st_nxt.tick = CNT_W'(INTERVAL - FIRST);
         if (st_r.busy && abort_i) begin
            st_nxt.busy = 1'b0;                                                 // [R22]
         end else if (st_r.busy) begin
            st_nxt.busy_cnt = st_r.busy_cnt - 1'b1;
            if (st_r.busy_cnt == '0) begin
               st_nxt.busy  = 1'b0;
               st_nxt.count = st_r.count + 1'b1;
            end
         end
      end else begin
         st_nxt.tick = st_r.tick + 1'b1;
         if (st_r.tick >= CNT_W'(INTERVAL - 1)) begin                        // [R10]
            st_nxt.tick     = '0;
            st_nxt.busy     = 1'b1;
            st_nxt.busy_cnt = CNT_W'(BUSY - 1);
         end else if (st_r.busy) begin
            st_nxt.busy_cnt = st_r.busy_cnt - 1'b1;
            if (st_r.busy_cnt == '0) begin
               st_nxt.busy  = 1'b0;
               st_nxt.count = st_r.count + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy_o  = st_r.busy;
   assign count_o = st_r.count;
endmodule // dsr_refresh_timer

/* dsr_self_refresh.sv */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Self-refresh control: entry decode, ODT/DLL handling, exit windows
module dsr_self_refresh
   import dsr_pkg::*;
#(
   parameter int EXIT_W = CNT_W
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   // Command pins (asynchronous to this clock)
   input  wire dsr_cmd_s         cmd_i,
   input  wire logic             odt_pin_i,
   // APB slave
   input  wire dsr_apb_req_s     apb_i,
   output dsr_apb_rsp_s          apb_o,
   // Device state
   output logic                  in_sr_o,
   output logic                  odt_en_o,
   output logic                  dll_en_o,
   output logic                  dll_rst_o,
   output logic                  int_clk_en_o,
   output logic                  vref_en_o,
   // Exit windows open
   output logic                  ok_non_dll_o,
   output logic                  ok_fast_o,
   output logic                  ok_dll_o,
   output logic                  ok_write_o
);
   initial begin
      if (EXIT_W < 10 || EXIT_W > 31)
         $error("dsr_self_refresh: EXIT_W out of range");
   end

   typedef struct packed {
      dsr_cmd_s         cmd_m;
      dsr_cmd_s         cmd_s;
      logic             odt_m;
      logic             odt_s;
      dsr_state_e       state;
      logic [31:0]      ctrl;
      logic [EXIT_W-1:0] t_xs;
      logic [EXIT_W-1:0] t_xsf;
      logic [EXIT_W-1:0] t_xsdll;
      logic [EXIT_W-1:0] t_xsab;
      logic [EXIT_W-1:0] t_cal;
      logic [EXIT_W-1:0] exit_cnt;
      logic              aborted;
      logic              odt_err;
      logic              dsel_err;
      logic [15:0]       sre_cnt;
      dsr_apb_rsp_s      rsp;
      logic              in_sr;
      logic              odt_en;
      logic              dll_en;
      logic              dll_rst;
      logic              clk_en;
      logic              vref_en;
      logic              ok_nd;
      logic              ok_f;
      logic              ok_d;
      logic              ok_w;
   } dsr_top_s;

   dsr_top_s          st_r, st_nxt;
   logic              tmr_busy;
   logic [CNT_W-1:0]  tmr_count;

   function automatic logic is_sre(input dsr_cmd_s c);
      is_sre = !c.cs_n && !c.ras_n && !c.cas_n && !c.cke && c.we_n && c.act_n;
   endfunction

   function automatic logic is_desel(input dsr_cmd_s c);
      is_desel = c.cs_n;
   endfunction

   dsr_refresh_timer u_timer (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .run_i     (st_r.state == ST_SR),
      .abort_i   (st_r.ctrl[CTRL_ABORT_BIT]),
      .busy_o    (tmr_busy),
      .count_o   (tmr_count)
   );

   logic [EXIT_W-1:0] cal_add;
   logic [EXIT_W-1:0] lim_nd;
   logic [EXIT_W-1:0] lim_f;
   logic [EXIT_W-1:0] lim_d;
   logic [EXIT_W-1:0] lim_w;
   logic [EXIT_W-1:0] lims [4];
   logic [3:0]        win_hit;
   logic              apb_acc;
   logic [31:0]       rdata;

   always_comb begin
      cal_add = st_r.ctrl[CTRL_CAL_EN_BIT] ? st_r.t_cal : '0;                  // [R20]
      lim_nd  = (st_r.aborted ? st_r.t_xsab : st_r.t_xs) + cal_add;            // [R22] [R21]
      lim_f   = st_r.t_xsf + cal_add;                                           // [R15]
      lim_d   = st_r.t_xsdll + cal_add;                                         // [R16]
      // Generator kept on: writes still wait the full tXS after an abort
      lim_w   = st_r.ctrl[CTRL_VREF_ON_BIT] ? st_r.t_xs + cal_add : lim_d;      // [R11]
      lims    = '{lim_nd, lim_f, lim_d, lim_w};
   end

   // Window order: non-DLL, fast, DLL, write
   generate
      for (genvar g = 0; g < 4; g++) begin : g_win
         assign win_hit[g] = (st_r.exit_cnt + 1'b1) >= lims[g];                 // [R24]
      end
   endgenerate

   assign apb_acc = apb_i.psel && apb_i.penable;

   always_comb begin
      case (apb_i.paddr)
         ADDR_CTRL:   rdata = st_r.ctrl;
         ADDR_STATUS: rdata = {24'h000000, st_r.dsel_err, st_r.odt_err, st_r.aborted,
                               tmr_busy, st_r.state};
         ADDR_REFCNT: rdata = {st_r.sre_cnt, tmr_count};
         ADDR_TXS:    rdata = 32'(st_r.t_xs);
         ADDR_TXSF:   rdata = 32'(st_r.t_xsf);
         ADDR_TXSDLL: rdata = 32'(st_r.t_xsdll);
         ADDR_TXSAB:  rdata = 32'(st_r.t_xsab);
         ADDR_TCAL:   rdata = 32'(st_r.t_cal);
         default:     rdata = 32'h0000_0000;
      endcase
   end

   always_comb begin
      st_nxt       = st_r;
      st_nxt.cmd_m = cmd_i;
      st_nxt.cmd_s = st_r.cmd_m;
      st_nxt.odt_m = odt_pin_i;
      st_nxt.odt_s = st_r.odt_m;
      st_nxt.dll_rst = 1'b0;

      // APB: answer in the access cycle, registered for one cycle
      st_nxt.rsp.pready  = apb_i.psel && !apb_i.penable;
      st_nxt.rsp.pslverr = 1'b0;
      if (apb_i.psel && !apb_i.penable) begin
         st_nxt.rsp.prdata = apb_i.pwrite ? 32'h0000_0000 : rdata;
         st_nxt.rsp.pslverr = (apb_i.paddr > ADDR_TCAL) || (apb_i.paddr[1:0] != 2'b00);
      end
      if (apb_acc && st_r.rsp.pready && apb_i.pwrite && !st_r.rsp.pslverr) begin
         case (apb_i.paddr)
            ADDR_CTRL:   st_nxt.ctrl    = {28'h0000000, apb_i.pwdata[3:0]};
            ADDR_STATUS: begin
               // Write one to clear; a new error in this cycle still wins
               if (apb_i.pwdata[6]) st_nxt.odt_err  = 1'b0;
               if (apb_i.pwdata[7]) st_nxt.dsel_err = 1'b0;
            end
            ADDR_TXS:    st_nxt.t_xs    = apb_i.pwdata[EXIT_W-1:0];             // [R24]
            ADDR_TXSF:   st_nxt.t_xsf   = apb_i.pwdata[EXIT_W-1:0];
            ADDR_TXSDLL: st_nxt.t_xsdll = apb_i.pwdata[EXIT_W-1:0];
            ADDR_TXSAB:  st_nxt.t_xsab  = apb_i.pwdata[EXIT_W-1:0];
            ADDR_TCAL:   st_nxt.t_cal   = apb_i.pwdata[EXIT_W-1:0];
            default:     st_nxt.ctrl    = st_r.ctrl;
         endcase
      end

      case (st_r.state)
         ST_IDLE: begin
            // Accepted in any refresh rate mode, no count tracking
            if (is_sre(st_r.cmd_s)) begin                                       // [R5] [R1]
               st_nxt.state   = ST_SR;
               st_nxt.sre_cnt = st_r.sre_cnt + 1'b1;
               st_nxt.odt_en  = 1'b0;                                           // [R8]
               st_nxt.dll_en  = 1'b0;                                           // [R9]
               st_nxt.clk_en  = 1'b0;                                           // [R10]
               st_nxt.vref_en = st_r.ctrl[CTRL_VREF_ON_BIT];                    // [R11]
               st_nxt.ok_nd   = 1'b0;
               st_nxt.ok_f    = 1'b0;
               st_nxt.ok_d    = 1'b0;
               st_nxt.ok_w    = 1'b0;
               st_nxt.aborted = 1'b0;
            end
         end
         ST_SR: begin
            // CKE alone ends self refresh; CS_n is checked only on the exit cycle
            if (st_r.cmd_s.cke) begin                                           // [R7] [R14]
               if (!is_desel(st_r.cmd_s)) st_nxt.dsel_err = 1'b1;
               st_nxt.state    = ST_EXIT;
               st_nxt.exit_cnt = '0;                                            // [R24]
               st_nxt.aborted  = tmr_busy && st_r.ctrl[CTRL_ABORT_BIT];         // [R22]
               st_nxt.odt_en   = 1'b1;                                          // [R8]
               st_nxt.dll_en   = st_r.ctrl[CTRL_DLL_EN_BIT];                    // [R9]
               st_nxt.dll_rst  = st_r.ctrl[CTRL_DLL_EN_BIT];                    // [R9]
               st_nxt.clk_en   = 1'b1;
               st_nxt.vref_en  = 1'b1;
            end
         end
         ST_EXIT: begin
            if (st_r.exit_cnt != {EXIT_W{1'b1}})
               st_nxt.exit_cnt = st_r.exit_cnt + 1'b1;
            if (win_hit[0]) begin                                               // [R14]
               st_nxt.ok_nd = 1'b1;
            end
            if (win_hit[1]) begin                                               // [R15]
               st_nxt.ok_f = 1'b1;
            end
            if (win_hit[2]) begin                                               // [R16]
               st_nxt.ok_d = 1'b1;
            end
            if (win_hit[3]) begin                                               // [R11]
               st_nxt.ok_w = 1'b1;
            end
            if (!st_r.ok_nd && !is_desel(st_r.cmd_s)) begin                     // [R17]
               st_nxt.dsel_err = 1'b1;
            end
            if (st_r.odt_s) begin                                               // [R18]
               st_nxt.odt_err = 1'b1;
            end
            if (!st_r.cmd_s.cke) begin
               st_nxt.state = ST_IDLE;
            end else if (st_r.ok_d && st_r.ok_nd) begin
               st_nxt.state = ST_POST;
            end
         end
         ST_POST: begin
            st_nxt.state = ST_IDLE;
         end
         default: begin
            st_nxt.state = ST_IDLE;
         end
      endcase
      st_nxt.in_sr = (st_nxt.state == ST_SR);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_r         <= '0;
         st_r.state   <= ST_IDLE;
         st_r.ctrl    <= CTRL_RST;
         st_r.t_xs    <= EXIT_W'(TXS_CYC);
         st_r.t_xsf   <= EXIT_W'(TXS_FAST_CYC);
         st_r.t_xsdll <= EXIT_W'(TXSDLL_CYC);
         st_r.t_xsab  <= EXIT_W'(TXS_ABORT_CYC);
         st_r.t_cal   <= EXIT_W'(TCAL_CYC);
         st_r.cmd_m   <= 6'h3f;
         st_r.cmd_s   <= 6'h3f;
         st_r.odt_en  <= 1'b1;
         st_r.dll_en  <= 1'b1;
         st_r.clk_en  <= 1'b1;
         st_r.vref_en <= 1'b1;
         st_r.ok_nd   <= 1'b1;
         st_r.ok_f    <= 1'b1;
         st_r.ok_d    <= 1'b1;
         st_r.ok_w    <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign in_sr_o      = st_r.in_sr;
   assign apb_o        = st_r.rsp;
   assign odt_en_o     = st_r.odt_en;
   assign dll_en_o     = st_r.dll_en;
   assign dll_rst_o    = st_r.dll_rst;
   assign int_clk_en_o = st_r.clk_en;
   assign vref_en_o    = st_r.vref_en;
   assign ok_non_dll_o = st_r.ok_nd;
   assign ok_fast_o    = st_r.ok_f;
   assign ok_dll_o     = st_r.ok_d;
   assign ok_write_o   = st_r.ok_w;
endmodule // dsr_self_refresh

/* dsr_self_refresh_asserts.sv */
`timescale 1ns/1ps
module dsr_self_refresh_asserts
   import dsr_pkg::*;
(
   // Clock and reset
   input wire logic         sys_clk_i,
   input wire logic         rst_i,
   // Pins and register bus
   input wire dsr_cmd_s     cmd_i,
   input wire dsr_apb_req_s apb_i,
   input wire dsr_apb_rsp_s apb_o,
   // Device state and exit windows
   input wire logic         in_sr_o,
   input wire logic         odt_en_o,
   input wire logic         dll_en_o,
   input wire logic         dll_rst_o,
   input wire logic         int_clk_en_o,
   input wire logic         ok_non_dll_o,
   input wire logic         ok_fast_o,
   input wire logic         ok_dll_o,
   input wire logic         ok_write_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   // Window allows for the two-flop pin synchroniser and the state register
   sequence s_entry_pins;
      cmd_i == 6'h12 && !in_sr_o && ok_dll_o;
   endsequence
   sequence s_exit;
      $fell(in_sr_o);
   endsequence
   sequence s_held_shut;
      (!ok_non_dll_o && !ok_fast_o) [*8];
   endsequence

   a_entry_decode: assert property (s_entry_pins |-> ##[2:5] in_sr_o)
      else $error("self refresh entry not taken");
   a_hold_sr: assert property (((!cmd_i.cke) [*4] ##0 in_sr_o) |=> in_sr_o)
      else $error("self refresh left while clock enable low");
   a_odt_off: assert property (in_sr_o |-> !odt_en_o)
      else $error("termination on in self refresh");
   a_odt_back: assert property (s_exit |-> odt_en_o)
      else $error("termination not restored at exit");
   a_dll_off: assert property (in_sr_o |-> !dll_en_o)
      else $error("dll on in self refresh");
   a_dll_relock: assert property (s_exit |-> dll_en_o && (dll_rst_o || $past(dll_rst_o) || $past(dll_rst_o, 2)))
      else $error("dll not restarted with reset at exit");
   a_clk_gated: assert property (in_sr_o |-> !int_clk_en_o)
      else $error("internal clock running in self refresh");
   a_windows_shut: assert property (in_sr_o |-> !(ok_non_dll_o || ok_fast_o || ok_dll_o || ok_write_o))
      else $error("exit window open in self refresh");
   a_exit_counted: assert property (s_exit |-> s_held_shut)
      else $error("exit window opened too early");
   a_write_gate: assert property (ok_write_o |-> ok_non_dll_o)
      else $error("write window before non dll window");
   a_bus_answer: assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready)
      else $error("register bus answer late");
   a_bus_pulse: assert property (apb_o.pready |=> !apb_o.pready)
      else $error("register bus ready held");
endmodule // dsr_self_refresh_asserts

bind dsr_self_refresh dsr_self_refresh_asserts u_asserts (
   .sys_clk_i, .rst_i, .cmd_i, .apb_i, .apb_o, .in_sr_o, .odt_en_o, .dll_en_o, .dll_rst_o,
   .int_clk_en_o, .ok_non_dll_o, .ok_fast_o, .ok_dll_o, .ok_write_o
);

/* dsr_ctrl_model.sv */
`timescale 1ns/1ps
module dsr_ctrl_model
   import dsr_pkg::*;
#(
   parameter int TRFC_WAIT = 50,
   parameter int TCKESR    = 8
) (
   // Clock
   input  wire logic sys_clk_i,
   // Pins toward the device
   output dsr_cmd_s  cmd_o,
   output logic      odt_o
);
   int mode      = 1;
   int fine_refs = 0;
   int avg_refs  = 0;

   initial begin
      cmd_o = 6'h3f;
      odt_o = 1'b0;
   end

   // Wait out the refresh cycle so the device is idle before the next command
   task automatic refresh(input bit counted);
      @(posedge sys_clk_i);
      cmd_o <= 6'h13;
      @(posedge sys_clk_i);
      cmd_o <= 6'h3f;
      repeat (TRFC_WAIT) @(posedge sys_clk_i);
      if (counted) begin
         fine_refs++;
         avg_refs++;
      end
   endtask

   task automatic sre();
      @(posedge sys_clk_i);
      cmd_o <= 6'h12;
      @(posedge sys_clk_i);
      cmd_o <= 6'h3e;
   endtask

   // Scrambled control pins and termination pin; only clock enable stays low
   // Clock never halts, so halt and restart windows hold trivially
   task automatic hold(input int n);
      for (int i = 0; i < n || i < TCKESR; i++) begin
         @(posedge sys_clk_i);
         cmd_o <= dsr_cmd_s'({i[4:0], 1'b0});
         odt_o <= i[0] & (i + 4 < n);
      end
   endtask

   // Deselect held until post_exit; bad_odt breaks the termination rule on purpose
   task automatic srx(input bit bad_odt);
      @(posedge sys_clk_i);
      cmd_o <= 6'h3f;
      odt_o <= bad_odt;
      repeat (3) @(posedge sys_clk_i);
      odt_o <= 1'b0;
   endtask

   // Called only once every exit window has elapsed; extras stay out of avg_refs
   task automatic post_exit();
      refresh(1'b0);
      if (fine_refs % mode != 0) refresh(1'b0);
      fine_refs = 0;
   endtask
endmodule // dsr_ctrl_model

/* dsr_self_refresh_tb.sv */
`timescale 1ns/1ps
module dsr_self_refresh_tb
   import dsr_pkg::*;
;
   localparam logic [31:0] AD [8] = '{ADDR_CTRL, ADDR_TXS, ADDR_TXSF, ADDR_TXSDLL, ADDR_TXSAB, ADDR_TCAL,
                                       32'h20, 32'h02};
   localparam logic [31:0] SHORT [4] = '{32'd30, 32'd12, 32'd60, 32'd10};
   logic         sys_clk_i = 1'b0;
   logic         rst_i     = 1'b1;
   dsr_cmd_s     cmd;
   logic         odt;
   dsr_apb_req_s apb_req   = '0;
   dsr_apb_rsp_s apb_rsp;
   logic         in_sr, odt_en, dll_en, dll_rst, clk_en, vref_en;
   logic         ok_non, ok_fast, ok_dll, ok_wr;
   logic [31:0]  rd;
   logic         err;
   logic [31:0]  exp_rst [8];
   int           t [3][4];
   int           mismatches      = 0;
   int           samples_checked = 0;

   dsr_self_refresh u_dut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_i(cmd), .odt_pin_i(odt), .apb_i(apb_req), .apb_o(apb_rsp),
      .in_sr_o(in_sr), .odt_en_o(odt_en), .dll_en_o(dll_en), .dll_rst_o(dll_rst), .int_clk_en_o(clk_en),
      .vref_en_o(vref_en), .ok_non_dll_o(ok_non), .ok_fast_o(ok_fast), .ok_dll_o(ok_dll), .ok_write_o(ok_wr)
   );
   dsr_ctrl_model u_ctl (.sys_clk_i(sys_clk_i), .cmd_o(cmd), .odt_o(odt));

   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      chk32(what, {31'h0, exp}, {31'h0, got});
   endtask

   // Waits for pready however long; only the watchdog ends a hung access
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
      int n;
      @(posedge sys_clk_i);
      apb_req <= '{1'b1, 1'b0, wr, addr, wdata};
      @(posedge sys_clk_i);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (apb_rsp.pready !== 1'b1);
      chk32("apb access edges", 32'd1, 32'(n));
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // Records the cycle after the exit edge at which each window opens
   task automatic measure(input int k);
      logic [3:0] oks;
      for (int j = 0; j < 4; j++) t[k][j] = 0;
      for (int i = 1; i <= 300; i++) begin
         @(posedge sys_clk_i);
         #1;
         oks = {ok_wr, ok_dll, ok_fast, ok_non};
         for (int j = 0; j < 4; j++) begin
            if (oks[j] === 1'b1 && t[k][j] == 0) t[k][j] = i;
         end
      end
   endtask

   task automatic sr_cycle(input int k, input int m, input int refs, input int hold, input logic [31:0] ctrl);
      int j;
      apb(1'b1, ADDR_CTRL, ctrl);
      u_ctl.mode = m;
      repeat (refs) u_ctl.refresh(1'b1);
      u_ctl.sre();
      j = 0;
      while (in_sr !== 1'b1 && j < 10) begin
         @(posedge sys_clk_i);
         j++;
      end
      #1;
      chk1("entered", 1'b1, in_sr);
      chk1("odt_en in sr", 1'b0, odt_en);
      chk1("dll_en in sr", 1'b0, dll_en);
      chk1("int_clk_en in sr", 1'b0, clk_en);
      chk1("vref_en in sr", ctrl[CTRL_VREF_ON_BIT], vref_en);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk32("status in sr", 32'h12, rd);
      u_ctl.hold(hold);
      chk1("held in sr", 1'b1, in_sr);
      u_ctl.srx(k == 2);
      measure(k);
      chk1("odt_en after exit", 1'b1, odt_en);
      chk1("dll_en after exit", 1'b1, dll_en);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk32("status flags", {25'h0, k == 2, ctrl[CTRL_ABORT_BIT], 5'h0}, rd & 32'he0);
      apb(1'b1, ADDR_STATUS, 32'he0);
      u_ctl.post_exit();
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Whole run is under two thousand cycles; this leaves a wide margin
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end

   initial begin
      exp_rst = '{CTRL_RST, ((TRFC1_NS + 10) * CLK_MHZ + 999) / 1000, TXS_FAST_CYC, TXSDLL_CYC, TXS_ABORT_CYC,
                  TCAL_CYC, 32'h0, 32'h0};
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, AD[i], 32'h0);
         chk32("reset value", exp_rst[i], rd);
         chk1("pslverr", i >= 6, err);
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, AD[i+1], SHORT[i]);
         apb(1'b0, AD[i+1], 32'h0);
         chk32("timing readback", SHORT[i], rd);
      end
      sr_cycle(0, 2, 3, 60, 32'h8);
      sr_cycle(1, 4, 4, 60, 32'hd);
      sr_cycle(2, 1, 1, 15, 32'ha);
      chk32("dll minus non dll", 32'd30, 32'(t[0][2] - t[0][0]));
      chk32("non dll minus fast", 32'd18, 32'(t[0][0] - t[0][1]));
      chk32("write minus dll", 32'd0, 32'(t[0][3] - t[0][2]));
      for (int j = 0; j < 3; j++) begin
         chk32("cal added", TCAL_CYC, 32'(t[1][j] - t[0][j]));
      end
      chk32("write minus non dll", 32'd0, 32'(t[1][3] - t[1][0]));
      chk32("abort dll minus non dll", 32'd50, 32'(t[2][2] - t[2][0]));
      apb(1'b0, ADDR_REFCNT, 32'h0);
      chk32("entry and refresh counts", 32'h0003_0002, rd);
      print_verdict();
   end
endmodule // dsr_self_refresh_tb
